// File: scs_serial_slave.sv
/*
  Clock-synchronous serial command port of a speech synthesis device.
  Assumes the host serial clock is far slower than ref_clk (pulse widths of
  62.5 ns or more against a 5 ns clock), so pins are oversampled.
*/
// Behaviour
// - With select low the host shifts command bits in MSB first, one per serial clock pulse, taken on the chosen capture edge.
// - A byte is complete and decoded on every eighth counted capture edge since selection.
// - While selected the status byte is shifted out on the serial output, paced by the serial clock.
// - At each falling edge of select the serial clock level is sampled and fixes the edge choice for the frame.
// - Clock high at select fall means capture on rising edges and drive output on falling edges.
// - Clock low at select fall means capture on falling edges and drive output on rising edges.
// - With select held low and no falling edge seen, capture defaults to rising and output to falling edges.
// - Select high clears bit count and partial byte and reloads the status byte; a held first duplicate copy is kept.
// - Select high puts the serial output in high impedance.
// - Every clock pulse while selected is counted, glitches too, with no resync except by deselection.
// - In duplicate mode each item is sent twice and accepted only when both copies match.
// - A duplicate mismatch sets the command error flag and discards the command.
`timescale 1ns/1ps
`include "scs_cfg.svh"

module scs_serial_slave (
  input wire logic ref_clk, // Device clock, 200 MHz
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic port_select_n, // Select pin, active low
  input wire logic sck, // Host serial clock pin
  input wire logic si, // Serial data in pin
  output logic so, // Serial data out value
  output logic so_oe, // Serial out enable, high while driven
  input wire scs_pkg::scs_byte_t status_byte, // Status to shift out
  input wire logic dup_mode, // Duplicate-entry mode, set at power-up
  input wire logic error_clear, // Clears the command error flag
  output scs_pkg::scs_byte_t cmd_data, // Accepted command byte
  output logic cmd_valid, // One-cycle pulse with cmd_data
  output logic command_error_flag // Sticky duplicate mismatch flag
);
  import scs_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic cs_s;
  logic sck_s;
  logic si_s;

  // Select resets low so a select tied low shows no falling edge
  scs_sync2 #(.RST_VAL(`SCS_CS_SYNC_RST)) u_sync_cs (
    .clk(ref_clk),
    .rst_n(nrst),
    .d(port_select_n),
    .q(cs_s)
  );
  scs_sync2 #(.RST_VAL(`SCS_SCK_SYNC_RST)) u_sync_sck (
    .clk(ref_clk),
    .rst_n(nrst),
    .d(sck),
    .q(sck_s)
  );
  scs_sync2 #(.RST_VAL(`SCS_SI_SYNC_RST)) u_sync_si (
    .clk(ref_clk),
    .rst_n(nrst),
    .d(si),
    .q(si_s)
  );

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  scs_state_t st;
  scs_state_t next_st;
  logic sel;
  logic cs_fall;
  logic sck_rise;
  logic sck_fall;
  logic cap_edge;
  logic out_edge;
  logic byte_done;
  scs_byte_t new_byte;
  logic armed;

  // Pins count only once both stages and the edge detector hold real
  // samples; a reset value differing from the pin would look like an edge
  assign armed = (st.warm == `SCS_WARM_DONE);
  assign sel = ~cs_s & armed;
  assign cs_fall = armed & st.cs_d & ~cs_s;
  assign sck_rise = sck_s & ~st.sck_d;
  assign sck_fall = ~sck_s & st.sck_d;
  assign cap_edge = st.mode_hi ? sck_rise : sck_fall;
  assign out_edge = st.mode_hi ? sck_fall : sck_rise;
  assign byte_done = sel & ~cs_fall & cap_edge & (st.bit_cnt == `SCS_CNT_LAST);
  assign new_byte = {st.in_sr[`SCS_MSB-1:0], si_s};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.cs_d = cs_s;
    next_st.sck_d = sck_s;
    next_st.cmd_valid = 1'b0;
    next_st.so_oe = sel;
    if (!armed) begin
      next_st.warm = st.warm + `SCS_WARM_ONE;
    end
    if (cs_fall) begin
      next_st.mode_hi = sck_s;
    end
    if (!sel) begin
      next_st.bit_cnt = `SCS_CNT_ZERO;
      next_st.in_sr = `SCS_BYTE_ZERO;
      next_st.out_cnt = `SCS_CNT_ZERO;
      next_st.out_sr = status_byte;
      next_st.so = status_byte[`SCS_MSB];
    end else if (!cs_fall) begin
      if (cap_edge) begin
        next_st.bit_cnt = st.bit_cnt + `SCS_CNT_ONE;
        next_st.in_sr = new_byte;
      end
      if (out_edge) begin
        next_st.out_cnt = st.out_cnt + `SCS_CNT_ONE;
        if (st.out_cnt == `SCS_CNT_LAST) begin
          next_st.out_sr = status_byte;
          next_st.so = status_byte[`SCS_MSB];
        end else begin
          next_st.out_sr = {st.out_sr[`SCS_MSB-1:0], 1'b0};
          next_st.so = st.out_sr[`SCS_MSB-1];
        end
      end
    end
    // Decode of a complete byte, with the optional duplicate check
    if (byte_done) begin
      if (!dup_mode) begin
        next_st.cmd_data = new_byte;
        next_st.cmd_valid = 1'b1;
        next_st.have_first = 1'b0;
      end else if (!st.have_first) begin
        next_st.first = new_byte;
        next_st.have_first = 1'b1;
      end else begin
        next_st.have_first = 1'b0;
        if (new_byte == st.first) begin
          next_st.cmd_data = new_byte;
          next_st.cmd_valid = 1'b1;
        end
      end
    end
    // Set wins over a clear in the same cycle
    if (error_clear) begin
      next_st.err = 1'b0;
    end
    if (byte_done && dup_mode && st.have_first && (new_byte != st.first)) begin
      next_st.err = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
      st.mode_hi <= `SCS_MODE_RST;
    end else begin
      st <= next_st;
    end
  end

  assign so = st.so;
  assign so_oe = st.so_oe;
  assign cmd_data = st.cmd_data;
  assign cmd_valid = st.cmd_valid;
  assign command_error_flag = st.err;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_byte_done;
    @(posedge ref_clk) disable iff (!nrst)
      (byte_done && !dup_mode) |=> (cmd_valid && cmd_data == $past(new_byte));
  endproperty
  a_byte_done: assert property (p_byte_done) else $error("byte not decoded");

  property p_out_shift;
    @(posedge ref_clk) disable iff (!nrst)
      (sel && !cs_fall && out_edge && st.out_cnt != `SCS_CNT_LAST)
        |=> (so == $past(st.out_sr[`SCS_MSB-1]));
  endproperty
  a_out_shift: assert property (p_out_shift) else $error("status bit not shifted");

  property p_mode_sample;
    @(posedge ref_clk) disable iff (!nrst)
      cs_fall |=> (st.mode_hi == $past(sck_s));
  endproperty
  a_mode_sample: assert property (p_mode_sample) else $error("edge mode not sampled");

  property p_cap_rise;
    @(posedge ref_clk) disable iff (!nrst)
      (sel && !cs_fall && st.mode_hi && sck_rise)
        |=> (st.bit_cnt == $past(st.bit_cnt) + `SCS_CNT_ONE);
  endproperty
  a_cap_rise: assert property (p_cap_rise) else $error("rising capture missed");

  property p_cap_fall;
    @(posedge ref_clk) disable iff (!nrst)
      (sel && !cs_fall && !st.mode_hi && sck_fall)
        |=> (st.bit_cnt == $past(st.bit_cnt) + `SCS_CNT_ONE);
  endproperty
  a_cap_fall: assert property (p_cap_fall) else $error("falling capture missed");

  property p_mode_hold;
    @(posedge ref_clk) disable iff (!nrst)
      !cs_fall |=> $stable(st.mode_hi);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("edge mode changed mid frame");

  property p_desel_clear;
    @(posedge ref_clk) disable iff (!nrst)
      !sel |=> (st.bit_cnt == `SCS_CNT_ZERO && st.in_sr == `SCS_BYTE_ZERO);
  endproperty
  a_desel_clear: assert property (p_desel_clear) else $error("deselect did not clear");

  property p_hiz;
    @(posedge ref_clk) disable iff (!nrst)
      cs_s |=> !so_oe;
  endproperty
  a_hiz: assert property (p_hiz) else $error("output driven while deselected");

  property p_no_count;
    @(posedge ref_clk) disable iff (!nrst)
      (sel && !cap_edge) |=> $stable(st.bit_cnt);
  endproperty
  a_no_count: assert property (p_no_count) else $error("count moved without edge");

  property p_dup_err;
    @(posedge ref_clk) disable iff (!nrst)
      (byte_done && dup_mode && st.have_first && new_byte != st.first)
        |=> (command_error_flag && !cmd_valid);
  endproperty
  a_dup_err: assert property (p_dup_err) else $error("mismatch not flagged");

  property p_dup_first;
    @(posedge ref_clk) disable iff (!nrst)
      (byte_done && dup_mode && !st.have_first) |=> !cmd_valid;
  endproperty
  a_dup_first: assert property (p_dup_first) else $error("first copy accepted");

  property p_cap_data;
    @(posedge ref_clk) disable iff (!nrst)
      (sel && !cs_fall && cap_edge) |=> (st.in_sr == $past(new_byte));
  endproperty
  a_cap_data: assert property (p_cap_data) else $error("serial bit not captured");

  property p_cmd_pulse;
    @(posedge ref_clk) disable iff (!nrst)
      cmd_valid |=> !cmd_valid;
  endproperty
  a_cmd_pulse: assert property (p_cmd_pulse) else $error("command strobe too long");

  property p_sel_drive;
    @(posedge ref_clk) disable iff (!nrst)
      sel |=> so_oe;
  endproperty
  a_sel_drive: assert property (p_sel_drive) else $error("output not driven");

  property p_reload;
    @(posedge ref_clk) disable iff (!nrst)
      (sel && !cs_fall && out_edge && st.out_cnt == `SCS_CNT_LAST)
        |=> (so == $past(status_byte[`SCS_MSB]));
  endproperty
  a_reload: assert property (p_reload) else $error("status not reloaded");

  property p_idle_load;
    @(posedge ref_clk) disable iff (!nrst)
      !sel |=> (st.out_cnt == `SCS_CNT_ZERO && so == $past(status_byte[`SCS_MSB]));
  endproperty
  a_idle_load: assert property (p_idle_load) else $error("idle state not restored");

  property p_out_count;
    @(posedge ref_clk) disable iff (!nrst)
      (sel && !cs_fall && out_edge)
        |=> (st.out_cnt == $past(st.out_cnt) + `SCS_CNT_ONE);
  endproperty
  a_out_count: assert property (p_out_count) else $error("output edge not counted");

  property p_dup_pass;
    @(posedge ref_clk) disable iff (!nrst)
      (byte_done && dup_mode && st.have_first && new_byte == st.first)
        |=> (cmd_valid && cmd_data == $past(new_byte));
  endproperty
  a_dup_pass: assert property (p_dup_pass) else $error("matching pair not accepted");

  property p_err_hold;
    @(posedge ref_clk) disable iff (!nrst)
      (command_error_flag && !error_clear) |=> command_error_flag;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error flag lost");

  property p_err_clear;
    @(posedge ref_clk) disable iff (!nrst)
      (error_clear && !byte_done) |=> !command_error_flag;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error flag not cleared");

  property p_warm_quiet;
    @(posedge ref_clk) disable iff (!nrst)
      !armed |=> (!so_oe && st.bit_cnt == `SCS_CNT_ZERO);
  endproperty
  a_warm_quiet: assert property (p_warm_quiet) else $error("active before warm-up");

endmodule : scs_serial_slave

// File: scs_cfg.svh
/*
  Constants of the serial command port: widths, counts and reset values.
  Assumes inclusion from the package and the design files by bare name.
*/
`ifndef SCS_CFG_SVH
`define SCS_CFG_SVH

`define SCS_BYTE_W 8
`define SCS_CNT_W 3
`define SCS_CNT_ZERO 3'h0
`define SCS_CNT_ONE 3'h1
`define SCS_CNT_LAST 3'h7
`define SCS_MSB 7
`define SCS_BYTE_ZERO 8'h00
`define SCS_MODE_RST 1'b1
`define SCS_CS_SYNC_RST 1'b0
`define SCS_SCK_SYNC_RST 1'b0
`define SCS_SI_SYNC_RST 1'b0
`define SCS_WARM_W 2
`define SCS_WARM_ONE 2'h1
`define SCS_WARM_DONE 2'h3

`endif

// File: scs_pkg.sv
/*
  Types of the serial command port.
  Assumes scs_cfg.svh is on the include path.
*/
`include "scs_cfg.svh"

package scs_pkg;

  typedef logic [`SCS_BYTE_W-1:0] scs_byte_t;
  typedef logic [`SCS_CNT_W-1:0] scs_cnt_t;
  typedef logic [`SCS_WARM_W-1:0] scs_warm_t;

  typedef struct packed {
    logic cs_d;
    logic sck_d;
    logic mode_hi;
    scs_cnt_t bit_cnt;
    scs_byte_t in_sr;
    scs_byte_t out_sr;
    scs_cnt_t out_cnt;
    scs_byte_t first;
    logic have_first;
    scs_byte_t cmd_data;
    logic cmd_valid;
    logic err;
    logic so;
    logic so_oe;
    scs_warm_t warm;
  } scs_state_t;

endpackage : scs_pkg

// File: scs_sync2.sv
/*
  Two flip-flop synchroniser for one level from outside the clock domain.
  Assumes the input is a plain level; only the second stage is used.
*/
`timescale 1ns/1ps

module scs_sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk, // Destination clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic d, // Asynchronous level
  output logic q // Synchronised level
);
  logic meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : scs_sync2

// File: scs_host_model.sv
/*
  Behavioural host that masters the serial command port.
  Assumes the bench resolves the serial output to Z while not enabled.
*/
`timescale 1ns/1ps

module scs_host_model (
  output logic sel_n, // Select, active low
  output logic sck, // Serial clock, 125 ns period in frames
  output logic si, // Serial data to the device
  input wire logic so_pin // Resolved serial output line
);
  logic [7:0] rx; // Status bits seen, MSB first
  initial begin
    sel_n = 1'b1;
    sck = 1'b1;
    si = 1'b0;
    rx = 8'h00;
  end
  // First toggle is the output edge, second the capture edge
  task automatic frame(input logic mode, input logic [15:0] d, input int n, input logic fr);
    #1.3;
    if (fr) begin
      sck = mode;
      #100 sel_n = 1'b0;
      #150;
    end
    si = ~d[n-1];
    #10;
    for (int i = n - 1; i >= 0; i--) begin
      rx = {rx[6:0], so_pin};
      sck = ~sck;
      #10 si = d[i];
      #52.5 sck = ~sck;
      // Junk on the line outside the capture window
      #52.5 si = (i > 0) ? ~d[i-1] : ~si;
      #10;
    end
    if (fr) begin
      #100 sel_n = 1'b1;
      #200;
    end
  endtask : frame
  task automatic hold_select(input logic lvl);
    sel_n = lvl;
  endtask : hold_select
endmodule : scs_host_model

// File: tb_top.sv
/*
  Self-checking bench of the serial command port.
  Assumes scs_cfg.svh on the include path and the host model beside it.
*/
`timescale 1ns/1ps

module tb_top;
  import scs_pkg::*;
  typedef struct {logic mode; logic [7:0] st; logic [7:0] cmd;} scs_row_t;
  logic ref_clk, nrst, port_select_n, sck, si, so, so_oe;
  logic dup_mode, error_clear, cmd_valid, command_error_flag;
  scs_byte_t status_byte, cmd_data;
  scs_byte_t got[$];
  int err_count = 0;
  int compares = 0;
  int hi_cnt = 0;
  wire so_pin = so_oe ? so : 1'bz;
  scs_row_t rows [4] = '{'{1'b1, 8'hA5, 8'h3C}, '{1'b0, 8'h5A, 8'hC3},
                         '{1'b1, 8'h80, 8'h01}, '{1'b0, 8'h01, 8'hFE}};

  scs_serial_slave u_dut (.ref_clk(ref_clk), .nrst(nrst), .port_select_n(port_select_n),
    .sck(sck), .si(si), .so(so), .so_oe(so_oe), .status_byte(status_byte),
    .dup_mode(dup_mode), .error_clear(error_clear), .cmd_data(cmd_data),
    .cmd_valid(cmd_valid), .command_error_flag(command_error_flag));
  scs_host_model u_host (.sel_n(port_select_n), .sck(sck), .si(si), .so_pin(so_pin));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Outputs are read half a cycle after the edge that launches them
  always @(negedge ref_clk) begin
    if (cmd_valid === 1'b1) got.push_back(cmd_data);
    hi_cnt <= (port_select_n === 1'b1) ? hi_cnt + 1 : 0;
    if (hi_cnt > 6) check("so_oe_idle", 8'h00, {7'h00, so_oe});
  end

  task automatic check(input string what, input logic [7:0] e, input logic [7:0] a);
    compares++;
    if (a !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, e, a);
    end
  endtask : check

  task automatic check_q(input logic [7:0] cnt, input logic [15:0] e);
    check("cmd_count", cnt, 8'(got.size()));
    foreach (got[i]) check("cmd_data", e[8*(int'(cnt)-1-i) +: 8], got[i]);
    got.delete();
  endtask : check_q

  task automatic do_reset;
    @(negedge ref_clk) nrst = 1'b0;
    repeat (12) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (6) @(negedge ref_clk);
  endtask : do_reset

  task automatic final_report;
    if (err_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    nrst = 1'b0;
    status_byte = 8'h00;
    dup_mode = 1'b0;
    error_clear = 1'b0;
    do_reset();
    foreach (rows[k]) begin
      @(negedge ref_clk) status_byte = rows[k].st;
      u_host.frame(rows[k].mode, {8'h00, rows[k].cmd}, 8, 1'b1);
      check("status", rows[k].st, u_host.rx);
      check_q(8'h01, {8'h00, rows[k].cmd});
    end
    u_host.frame(1'b0, 16'h9C63, 16, 1'b1);
    check_q(8'h02, 16'h9C63);
    u_host.frame(1'b1, 16'h0015, 5, 1'b1);
    u_host.frame(1'b1, 16'h00E7, 8, 1'b1);
    check_q(8'h01, 16'h00E7);
    u_host.frame(1'b1, 16'h014B, 9, 1'b1);
    check_q(8'h01, 16'h00A5);
    u_host.hold_select(1'b0);
    do_reset();
    u_host.frame(1'b1, 16'h0069, 8, 1'b0);
    #200;
    check("so_oe_sel", 8'h01, {7'h00, so_oe});
    check("status_tied", rows[3].st, u_host.rx);
    check_q(8'h01, 16'h0069);
    u_host.hold_select(1'b1);
    @(negedge ref_clk) dup_mode = 1'b1;
    do_reset();
    u_host.frame(1'b0, 16'h5A5A, 16, 1'b1);
    check_q(8'h01, 16'h005A);
    check("err_flag", 8'h00, {7'h00, command_error_flag});
    u_host.frame(1'b0, 16'h5AA5, 16, 1'b1);
    check_q(8'h00, 16'h0000);
    check("err_flag", 8'h01, {7'h00, command_error_flag});
    @(negedge ref_clk) error_clear = 1'b1;
    @(negedge ref_clk) error_clear = 1'b0;
    @(negedge ref_clk);
    check("err_clr", 8'h00, {7'h00, command_error_flag});
    final_report();
  end

  initial begin
    #200000;
    err_count++;
    final_report();
  end
endmodule : tb_top
